// *** verilog/urd_top.sv ***
// serial port register set: host and controller decode, aliasing, config registers
// =====================================================================
// Overview of operation
// - A read at offset 0 with divisor access clear returns the receive buffer, read-only.
// - A write at offset 0 with divisor access clear loads the write-only transmit buffer.
// - Line format bit 7 maps offsets 0 and 1 to the divisor bytes, else offset 1 is irq enable.
// - Offset 2 writes fifo control and reads irq identification whatever the divisor bit.
// - Line format at offset 3 is read/write from both sides regardless of the divisor bit.
// - Offsets 5 and 6 read line state and modem state, read-only, from both sides.
// - Only byte accesses are meant; wider stores are blocked and wider loads are undefined.
// - Host runtime addresses are the programmed base address plus index 0 to 7.
// - Controller addresses are the fixed bus base plus offset, in lane offset modulo four.
// - Host config selects this block by logical device 7, activate 30h, select F0h.
// - A config select bit chooses standby or main power reset for the runtime registers.
// - All registers run on the single bus clock.
`timescale 1ns/1ns
`include "urd_defines.svh"

module urd_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        main_rst_n,
    // host runtime i/o
    input  wire logic        io_valid,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    output logic             io_rvalid,
    // host configuration port
    input  wire logic        cfg_valid,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_ldn,
    input  wire logic [7:0]  cfg_index,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic [15:0] host_base_addr,
    output logic [7:0]       cfg_rdata,
    output logic             cfg_rvalid,
    // controller peripheral bus
    input  wire logic        ec_valid,
    input  wire logic        ec_write,
    input  wire logic [23:0] ec_addr,
    input  wire logic [1:0]  ec_size,
    input  wire logic [31:0] ec_wdata,
    output logic [31:0]      ec_rdata,
    output logic             ec_rvalid,
    // serial engine side
    input  wire logic [7:0]  rx_data_buffer,
    input  wire logic [7:0]  irq_ident,
    input  wire logic [7:0]  line_state,
    input  wire logic [7:0]  modem_state,
    output logic [7:0]       tx_data_buffer,
    output logic             tx_load,
    output logic             rx_read,
    output logic [7:0]       fifo_ctrl,
    output logic             fifo_ctrl_load,
    output logic [15:0]      baud_divisor,
    output logic [7:0]       irq_enable,
    output logic [7:0]       line_format,
    output logic [7:0]       modem_ctrl,
    output logic [7:0]       block_activate,
    output logic [7:0]       config_select
);
    urd_pkg::urd_access_t host_acc;
    urd_pkg::urd_access_t ec_acc;
    urd_pkg::urd_access_t acc;
    urd_pkg::urd_src_t    src;
    logic                 ec_cfg_act;
    logic                 ec_cfg_csel;
    logic                 ec_cfg_rd;
    logic [7:0]           ec_cfg_wdata;
    logic [7:0]           scratch_byte;
    logic                 divisor_access_bit;
    logic                 main_s1;
    logic                 main_s2;
    logic                 rt_rst;
    logic                 cfg_sel;
    logic                 cfg_host_act_wr;
    logic                 cfg_host_csel_wr;
    logic [1:0]           ec_lane;
    logic [7:0]           next_rdata;

    // =====================================================================
    // address decoders
    urd_host_decode u_host (
        .core_clk  (core_clk),
        .rst       (rst),
        .io_valid  (io_valid),
        .io_write  (io_write),
        .io_addr   (io_addr),
        .io_wdata  (io_wdata),
        .base_addr (host_base_addr),
        .active    (block_activate[`URD_ACT_EN_BIT]),
        .acc       (host_acc)
    );

    urd_ec_decode u_ec (
        .core_clk     (core_clk),
        .rst          (rst),
        .ec_valid     (ec_valid),
        .ec_write     (ec_write),
        .ec_addr      (ec_addr),
        .ec_size      (ec_size),
        .ec_wdata     (ec_wdata),
        .acc          (ec_acc),
        .cfg_hit_act  (ec_cfg_act),
        .cfg_hit_csel (ec_cfg_csel),
        .cfg_wdata    (ec_cfg_wdata)
    );

    // the controller wins when both sides hit in one cycle; the host access is dropped,
    // which is acceptable since the two never share the port in normal use
    always_comb begin
        if (ec_acc.valid) begin
            acc = ec_acc;
            src = urd_pkg::URD_SRC_EC;
        end else if (host_acc.valid) begin
            acc = host_acc;
            src = urd_pkg::URD_SRC_HOST;
        end else begin
            acc = '0;
            src = urd_pkg::URD_SRC_NONE;
        end
    end

    assign divisor_access_bit = line_format[`URD_LCR_DIVISOR_ACCESS_BIT_BIT];

    // =====================================================================
    // reset selection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_s1 <= 1'b0;
            main_s2 <= 1'b0;
        end else begin
            main_s1 <= main_rst_n;
            main_s2 <= main_s1;
        end
    end

    // power bit set: main power reset also clears the runtime registers
    assign rt_rst = rst || (config_select[`URD_CSEL_POWER_BIT] && !main_s2);

    // =====================================================================
    // configuration registers
    assign cfg_sel          = cfg_valid && (cfg_ldn == `URD_LDN);
    assign cfg_host_act_wr  = cfg_sel && cfg_write && (cfg_index == `URD_CFG_ACT_IDX);
    assign cfg_host_csel_wr = cfg_sel && cfg_write && (cfg_index == `URD_CFG_CSEL_IDX);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            block_activate <= `URD_ZERO_BYTE;
        end else if (cfg_host_act_wr) begin
            block_activate <= cfg_wdata;
        end else if (ec_cfg_act && ec_acc.write) begin
            block_activate <= ec_cfg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            config_select <= `URD_ZERO_BYTE;
        end else if (cfg_host_csel_wr) begin
            config_select <= cfg_wdata;
        end else if (ec_cfg_csel && ec_acc.write) begin
            config_select <= ec_cfg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_rdata  <= `URD_ZERO_BYTE;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_sel && !cfg_write;
            if (cfg_sel && !cfg_write && cfg_index == `URD_CFG_ACT_IDX) begin
                cfg_rdata <= block_activate;
            end else if (cfg_sel && !cfg_write && cfg_index == `URD_CFG_CSEL_IDX) begin
                cfg_rdata <= config_select;
            end else begin
                cfg_rdata <= `URD_ZERO_BYTE;
            end
        end
    end

    // =====================================================================
    // runtime register writes
    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            line_format <= `URD_ZERO_BYTE;
        end else if (acc.valid && acc.write && acc.offset == `URD_OFS_LCR) begin
            line_format <= acc.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            baud_divisor <= 16'h0000;
        end else if (acc.valid && acc.write && divisor_access_bit) begin
            if (acc.offset == `URD_OFS_DATA) begin
                baud_divisor[7:0] <= acc.wdata;
            end else if (acc.offset == `URD_OFS_IER_DLH) begin
                baud_divisor[15:8] <= acc.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            irq_enable <= `URD_ZERO_BYTE;
        end else if (acc.valid && acc.write && !divisor_access_bit && acc.offset == `URD_OFS_IER_DLH) begin
            irq_enable <= acc.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            modem_ctrl   <= `URD_ZERO_BYTE;
            scratch_byte <= `URD_ZERO_BYTE;
        end else if (acc.valid && acc.write) begin
            if (acc.offset == `URD_OFS_MCR) begin
                modem_ctrl <= acc.wdata;
            end
            if (acc.offset == `URD_OFS_SCR) begin
                scratch_byte <= acc.wdata;
            end
        end
    end

    // transmit and fifo control are write-only strobes toward the serial engine
    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            tx_data_buffer <= `URD_ZERO_BYTE;
            tx_load        <= 1'b0;
        end else begin
            tx_load <= acc.valid && acc.write && !divisor_access_bit && acc.offset == `URD_OFS_DATA;
            if (acc.valid && acc.write && !divisor_access_bit && acc.offset == `URD_OFS_DATA) begin
                tx_data_buffer <= acc.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rt_rst) begin
            fifo_ctrl      <= `URD_ZERO_BYTE;
            fifo_ctrl_load <= 1'b0;
        end else begin
            fifo_ctrl_load <= acc.valid && acc.write && acc.offset == `URD_OFS_IIR_FCR;
            if (acc.valid && acc.write && acc.offset == `URD_OFS_IIR_FCR) begin
                fifo_ctrl <= acc.wdata;
            end
        end
    end

    // =====================================================================
    // read mux
    always_comb begin
        next_rdata = `URD_ZERO_BYTE;
        unique case (acc.offset)
            `URD_OFS_DATA:    next_rdata = divisor_access_bit ? baud_divisor[7:0] : rx_data_buffer;
            `URD_OFS_IER_DLH: next_rdata = divisor_access_bit ? baud_divisor[15:8] : irq_enable;
            `URD_OFS_IIR_FCR: next_rdata = irq_ident;
            `URD_OFS_LCR:     next_rdata = line_format;
            `URD_OFS_MCR:     next_rdata = modem_ctrl;
            `URD_OFS_LSR:     next_rdata = line_state;
            `URD_OFS_MSR:     next_rdata = modem_state;
            `URD_OFS_SCR:     next_rdata = scratch_byte;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_read <= 1'b0;
        end else begin
            rx_read <= acc.valid && !acc.write && !divisor_access_bit && acc.offset == `URD_OFS_DATA;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_rdata  <= `URD_ZERO_BYTE;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= (src == urd_pkg::URD_SRC_HOST) && !acc.write;
            io_rdata  <= (src == urd_pkg::URD_SRC_HOST && !acc.write) ? next_rdata
                                                                        : `URD_ZERO_BYTE;
        end
    end

    assign ec_lane   = acc.offset[1:0];
    assign ec_cfg_rd = (ec_cfg_act || ec_cfg_csel) && !ec_acc.write;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ec_rdata  <= 32'h00000000;
            ec_rvalid <= 1'b0;
        end else begin
            ec_rvalid <= ((src == urd_pkg::URD_SRC_EC) && !acc.write) || ec_cfg_rd;
            if (ec_cfg_rd) begin
                // both config registers sit in lane 0
                ec_rdata <= {24'h000000, ec_cfg_act ? block_activate : config_select};
            end else begin
                ec_rdata <= (src == urd_pkg::URD_SRC_EC && !acc.write)
                            ? (32'({24'h000000, next_rdata}) << {ec_lane, 3'b000})
                            : 32'h00000000;
            end
        end
    end

    // =====================================================================
    // checks
    AST_DIVISOR_ACCESS_BIT_READ0: assert property (@(posedge core_clk) disable iff (rst)
        (src == urd_pkg::URD_SRC_HOST && !acc.write && !divisor_access_bit
         && acc.offset == `URD_OFS_DATA) |=> io_rdata == $past(rx_data_buffer))
        else $error("offset 0 read did not return receive buffer");

    AST_TX_LOAD: assert property (@(posedge core_clk) disable iff (rt_rst)
        (acc.valid && acc.write && !divisor_access_bit && acc.offset == `URD_OFS_DATA)
        |=> tx_load && tx_data_buffer == $past(acc.wdata))
        else $error("transmit buffer not loaded");

    AST_DIV_LOW: assert property (@(posedge core_clk) disable iff (rt_rst)
        (acc.valid && acc.write && divisor_access_bit && acc.offset == `URD_OFS_DATA)
        |=> baud_divisor[7:0] == $past(acc.wdata) && !tx_load)
        else $error("divisor low byte not written");

    AST_IER_HOLD: assert property (@(posedge core_clk) disable iff (rt_rst)
        (acc.valid && acc.write && divisor_access_bit) |=> $stable(irq_enable))
        else $error("irq enable changed while divisor access set");

    AST_FCR: assert property (@(posedge core_clk) disable iff (rt_rst)
        (acc.valid && acc.write && acc.offset == `URD_OFS_IIR_FCR) |=> fifo_ctrl_load)
        else $error("fifo control strobe missing");

    AST_LCR_WR: assert property (@(posedge core_clk) disable iff (rt_rst)
        (acc.valid && acc.write && acc.offset == `URD_OFS_LCR)
        |=> line_format == $past(acc.wdata))
        else $error("line format not written");

    AST_LSR_RD: assert property (@(posedge core_clk) disable iff (rst)
        (src == urd_pkg::URD_SRC_HOST && !acc.write && acc.offset == `URD_OFS_LSR)
        |=> io_rdata == $past(line_state))
        else $error("line state read wrong");

    AST_WIDE_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
        (ec_valid && ec_write && ec_size != `URD_SIZE_BYTE) |=> !ec_acc.valid)
        else $error("wide store not blocked");

    AST_CFG_ACT: assert property (@(posedge core_clk) disable iff (rst)
        cfg_host_act_wr |=> block_activate == $past(cfg_wdata))
        else $error("activate not written by config port");

endmodule : urd_top

// *** verilog/urd_defines.svh ***
// offsets, field positions and reset values for the serial port register decode
`ifndef URD_DEFINES_SVH
`define URD_DEFINES_SVH

`define URD_OFS_DATA       3'h0
`define URD_OFS_IER_DLH    3'h1
`define URD_OFS_IIR_FCR    3'h2
`define URD_OFS_LCR        3'h3
`define URD_OFS_MCR        3'h4
`define URD_OFS_LSR        3'h5
`define URD_OFS_MSR        3'h6
`define URD_OFS_SCR        3'h7

`define URD_EC_BASE        24'hff1c00
`define URD_EC_ACT_OFS     12'h330
`define URD_EC_CSEL_OFS    12'h3f0
`define URD_LDN            8'h07
`define URD_CFG_ACT_IDX    8'h30
`define URD_CFG_CSEL_IDX   8'hf0

`define URD_LCR_DIVISOR_ACCESS_BIT_BIT   7
`define URD_CSEL_POWER_BIT 1
`define URD_ACT_EN_BIT     0

`define URD_SIZE_BYTE      2'h0
`define URD_ZERO_BYTE      8'h00
`define URD_IIR_RESET      8'h01
`define URD_LSR_RESET      8'h60

`endif

// *** verilog/urd_pkg.sv ***
// types shared by the serial port register decode
package urd_pkg;

    // one register access as seen by the common decode
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] offset;
        logic [7:0] wdata;
    } urd_access_t;

    typedef enum logic [1:0] {
        URD_SRC_NONE = 2'b00,
        URD_SRC_HOST = 2'b01,
        URD_SRC_EC   = 2'b11
    } urd_src_t;

endpackage : urd_pkg

// *** verilog/urd_host_decode.sv ***
// host-side runtime address match: base address plus index 0..7
`timescale 1ns/1ns
`include "urd_defines.svh"

module urd_host_decode (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              io_valid,
    input  wire logic              io_write,
    input  wire logic [15:0]       io_addr,
    input  wire logic [7:0]        io_wdata,
    input  wire logic [15:0]       base_addr,
    input  wire logic              active,
    output urd_pkg::urd_access_t   acc
);
    logic [15:0] delta;

    assign delta = io_addr - base_addr;

    // =====================================================================
    // address match
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc <= '0;
        end else begin
            acc.valid  <= io_valid && active && (delta[15:3] == 13'h0000);
            acc.write  <= io_write;
            acc.offset <= delta[2:0];
            acc.wdata  <= io_wdata;
        end
    end

endmodule : urd_host_decode

// *** verilog/urd_ec_decode.sv ***
// controller-side address match: fixed bus base plus offset, byte lane select, byte-only stores
`timescale 1ns/1ns
`include "urd_defines.svh"

module urd_ec_decode (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ec_valid,
    input  wire logic              ec_write,
    input  wire logic [23:0]       ec_addr,
    input  wire logic [1:0]        ec_size,
    input  wire logic [31:0]       ec_wdata,
    output urd_pkg::urd_access_t   acc,
    output logic                   cfg_hit_act,
    output logic                   cfg_hit_csel,
    output logic [7:0]             cfg_wdata
);
    logic [11:0] ofs;
    logic        in_block;
    logic [7:0]  lane_byte;
    logic        byte_ok;

    // the block's window is 1 KB aligned, so the upper bits name the block
    assign ofs       = {2'b00, ec_addr[9:0]};
    assign in_block  = (ec_addr[23:10] == 14'(`URD_EC_BASE >> 10));
    // data sits in the lane given by offset modulo four
    assign lane_byte = ec_wdata[{ec_addr[1:0], 3'b000} +: 8];
    // wide stores are dropped; wide loads are let through with undefined data
    assign byte_ok   = (ec_size == `URD_SIZE_BYTE) || !ec_write;

    // =====================================================================
    // address match
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc          <= '0;
            cfg_hit_act  <= 1'b0;
            cfg_hit_csel <= 1'b0;
            cfg_wdata    <= `URD_ZERO_BYTE;
        end else begin
            acc.valid    <= ec_valid && in_block && byte_ok && (ofs[11:3] == 9'h000);
            acc.write    <= ec_write;
            acc.offset   <= ofs[2:0];
            acc.wdata    <= lane_byte;
            // hits cover reads and writes; acc.write tells them apart
            cfg_hit_act  <= ec_valid && in_block && byte_ok
                            && (ofs == `URD_EC_ACT_OFS);
            cfg_hit_csel <= ec_valid && in_block && byte_ok
                            && (ofs == `URD_EC_CSEL_OFS);
            cfg_wdata    <= lane_byte;
        end
    end

endmodule : urd_ec_decode

// *** dv/urd_engine_model.sv ***
// serial engine stand-in feeding status levels and a receive byte to the register decode
`timescale 1ns/1ns

module urd_engine_model (
    input  wire logic  core_clk,
    input  wire logic  rst,
    input  wire logic  rx_read,
    output logic [7:0] rx_data_buffer,
    output logic [7:0] irq_ident,
    output logic [7:0] line_state,
    output logic [7:0] modem_state
);
    // =====================================================================
    // status levels
    // fixed status keeps expectations simple; only the receive byte moves
    assign irq_ident   = 8'h01;
    assign line_state  = 8'h60;
    assign modem_state = 8'hb0;

    // each pop hands the next byte, so a read with a stray pop shows up later
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_data_buffer <= 8'h3c;
        end else if (rx_read) begin
            rx_data_buffer <= rx_data_buffer + 8'h01;
        end
    end
endmodule : urd_engine_model

// *** dv/uart_register_decode_test.sv ***
// self-checking bench for the serial port register decode over host, config and controller ports
`timescale 1ns/1ns
`include "urd_defines.svh"

module uart_register_decode_test;
    localparam logic [15:0] BASE = 16'h03f8;
    logic        core_clk, rst, main_rst_n, io_valid, io_write, io_rvalid;
    logic        cfg_valid, cfg_write, cfg_rvalid, ec_valid, ec_write, ec_rvalid;
    logic        tx_load, rx_read, fifo_ctrl_load;
    logic [15:0] io_addr, host_base_addr, baud_divisor;
    logic [7:0]  io_wdata, io_rdata, cfg_ldn, cfg_index, cfg_wdata, cfg_rdata;
    logic [7:0]  rx_data_buffer, irq_ident, line_state, modem_state, tx_data_buffer;
    logic [7:0]  fifo_ctrl, irq_enable, line_format, modem_ctrl, block_activate, config_select;
    logic [23:0] ec_addr;
    logic [1:0]  ec_size;
    logic [31:0] ec_wdata, ec_rdata;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n_tx = 0;
    wire         any_rv = io_rvalid | cfg_rvalid | ec_rvalid;
    wire  [31:0] any_rd = io_rvalid ? {24'h0, io_rdata} : cfg_rvalid ? {24'h0, cfg_rdata} : ec_rdata;

    urd_top dut_u (
        .core_clk, .rst, .main_rst_n, .io_valid, .io_write, .io_addr, .io_wdata, .io_rdata,
        .io_rvalid, .cfg_valid, .cfg_write, .cfg_ldn, .cfg_index, .cfg_wdata,
        .host_base_addr, .cfg_rdata, .cfg_rvalid, .ec_valid, .ec_write, .ec_addr, .ec_size,
        .ec_wdata, .ec_rdata, .ec_rvalid, .rx_data_buffer, .irq_ident, .line_state,
        .modem_state, .tx_data_buffer, .tx_load, .rx_read, .fifo_ctrl, .fifo_ctrl_load,
        .baud_divisor, .irq_enable, .line_format, .modem_ctrl, .block_activate, .config_select
    );
    urd_engine_model eng_u (
        .core_clk, .rst, .rx_read, .rx_data_buffer, .irq_ident, .line_state, .modem_state
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (tx_load === 1'b1) n_tx++;
    end

    // =====================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request was raised just after an edge; answers come within two cycles
    task automatic wait_ans(input logic w, input logic ans, input logic [31:0] e);
        logic        seen;
        logic [31:0] got;
        seen = 1'b0;
        got = 32'h0;
        @(posedge core_clk);
        #1;
        io_valid = 1'b0;
        cfg_valid = 1'b0;
        ec_valid = 1'b0;
        repeat (4) begin
            if (any_rv === 1'b1) begin
                seen = 1'b1;
                got = any_rd;
            end
            @(posedge core_clk);
            #1;
        end
        chk(32'(seen), 32'(!w && ans));
        if (!w && ans) chk(got, e);
    endtask : wait_ans

    task automatic host(input logic w, input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] e, input logic ans);
        io_write = w;
        io_addr = a;
        io_wdata = d;
        io_valid = 1'b1;
        wait_ans(w, ans, 32'(e));
    endtask : host

    task automatic cfg(input logic w, input logic [7:0] logical_device_number, input logic [7:0] idx,
                       input logic [7:0] d, input logic [7:0] e, input logic ans);
        cfg_write = w;
        cfg_ldn = logical_device_number;
        cfg_index = idx;
        cfg_wdata = d;
        cfg_valid = 1'b1;
        wait_ans(w, ans, 32'(e));
    endtask : cfg

    task automatic ec(input logic w, input logic [23:0] a, input logic [1:0] s,
                      input logic [31:0] d, input logic [31:0] e);
        ec_write = w;
        ec_addr = a;
        ec_size = s;
        ec_wdata = d;
        ec_valid = 1'b1;
        wait_ans(w, 1'b1, e);
    endtask : ec

    task automatic main_pulse;
        main_rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        main_rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : main_pulse

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // the sequence takes a few hundred cycles; a hang ends here instead
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    // =====================================================================
    // test sequence
    initial begin
        {rst, main_rst_n, io_valid, io_write, cfg_valid, cfg_write, ec_valid, ec_write} = 8'hc0;
        {io_addr, io_wdata, cfg_ldn, cfg_index, cfg_wdata, ec_addr, ec_size, ec_wdata} = '0;
        host_base_addr = BASE;
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk(32'(line_format), 32'h0);
        host(1'b0, BASE + 16'h7, 8'h0, 8'h0, 1'b0);
        cfg(1'b1, 8'h06, `URD_CFG_ACT_IDX, 8'h01, 8'h0, 1'b0);
        chk(32'(block_activate), 32'h0);
        cfg(1'b1, `URD_LDN, `URD_CFG_ACT_IDX, 8'h01, 8'h0, 1'b0);
        cfg(1'b0, `URD_LDN, `URD_CFG_ACT_IDX, 8'h0, 8'h01, 1'b1);
        $display("test activation done");
        host(1'b1, BASE + 16'h7, 8'ha5, 8'h0, 1'b0);
        host(1'b0, BASE + 16'h7, 8'h0, 8'ha5, 1'b1);
        host(1'b0, BASE + 16'h8, 8'h0, 8'h0, 1'b0);
        host(1'b0, BASE - 16'h1, 8'h0, 8'h0, 1'b0);
        host(1'b1, BASE + 16'h3, 8'h03, 8'h0, 1'b0);
        host(1'b0, BASE + 16'h3, 8'h0, 8'h03, 1'b1);
        host(1'b0, BASE, 8'h0, 8'h3c, 1'b1);
        host(1'b0, BASE, 8'h0, 8'h3d, 1'b1);
        host(1'b1, BASE, 8'h5a, 8'h0, 1'b0);
        chk(32'(tx_data_buffer), 32'h5a);
        chk(32'(n_tx), 32'h1);
        $display("test host decode done");
        host(1'b1, BASE + 16'h3, 8'h83, 8'h0, 1'b0);
        host(1'b1, BASE, 8'h34, 8'h0, 1'b0);
        host(1'b1, BASE + 16'h1, 8'h12, 8'h0, 1'b0);
        chk(32'(baud_divisor), 32'h1234);
        chk(32'(n_tx), 32'h1);
        chk(32'(irq_enable), 32'h0);
        host(1'b0, BASE, 8'h0, 8'h34, 1'b1);
        host(1'b0, BASE + 16'h1, 8'h0, 8'h12, 1'b1);
        host(1'b1, BASE + 16'h2, 8'hc1, 8'h0, 1'b0);
        chk(32'(fifo_ctrl), 32'hc1);
        host(1'b0, BASE + 16'h2, 8'h0, 8'h01, 1'b1);
        host(1'b0, BASE + 16'h3, 8'h0, 8'h83, 1'b1);
        host(1'b1, BASE + 16'h3, 8'h03, 8'h0, 1'b0);
        host(1'b1, BASE + 16'h1, 8'h0f, 8'h0, 1'b0);
        chk(32'(irq_enable), 32'h0f);
        chk(32'(baud_divisor), 32'h1234);
        host(1'b0, BASE, 8'h0, 8'h3e, 1'b1);
        host(1'b1, BASE + 16'h5, 8'hff, 8'h0, 1'b0);
        host(1'b0, BASE + 16'h5, 8'h0, 8'h60, 1'b1);
        host(1'b0, BASE + 16'h6, 8'h0, 8'hb0, 1'b1);
        $display("test aliasing done");
        ec(1'b0, 24'hff1c03, 2'h0, 32'h0, 32'h03000000);
        ec(1'b1, 24'hff1c04, 2'h0, 32'h00000013, 32'h0);
        chk(32'(modem_ctrl), 32'h13);
        ec(1'b1, 24'hff1c04, 2'h2, 32'hffffffff, 32'h0);
        ec(1'b1, 24'hff1c04, 2'h1, 32'hffffffff, 32'h0);
        chk(32'(modem_ctrl), 32'h13);
        ec(1'b0, 24'hff1c05, 2'h0, 32'h0, 32'h00006000);
        ec(1'b0, 24'hff1c06, 2'h0, 32'h0, 32'h00b00000);
        ec(1'b0, 24'hff1c02, 2'h0, 32'h0, 32'h00010000);
        ec(1'b0, 24'hff1c00, 2'h0, 32'h0, 32'h0000003f);
        $display("test controller side done");
        main_pulse();
        chk(32'(line_format), 32'h03);
        ec(1'b1, 24'hff1ff0, 2'h0, 32'h00000002, 32'h0);
        chk(32'(config_select), 32'h02);
        ec(1'b0, 24'hff1ff0, 2'h0, 32'h0, 32'h00000002);
        main_pulse();
        chk(32'(line_format), 32'h0);
        ec(1'b0, 24'hff1c07, 2'h0, 32'h0, 32'h0);
        $display("test power reset select done");
        final_report();
    end
endmodule : uart_register_decode_test
